// ### hdl/msi_pkg.sv
// Functional notes
// - Status bits live at 0x14 and 0x2F
// - Enables at 0x06 and 0x2D decide interrupts
// - Gate event with enable, then set status
// - Writing 0x14 clears and rearms pending interrupts
// - Per-pin push-pull and active-high bits at 0x33
// - Sample-ready flag always live, read clears it
// - Sample flag per sample; request needs enable
// - Incline/inversion need feature bit 0
// - Any-motion needs feature bit 2, status bit 2
// - Jolt needs feature bit 3, status bit 3
// - Steep-incline needs feature bit 4, status bit 4
// - Jolt/steep need any-motion feature, not enable
// - Queue flags active only with queue enable
// - Queue-empty reads 1 after reset, enable bit 0
// - Queue-full reads 0 after reset, enable bit 1
// - Threshold flag 0, threshold count defaults 16
// - Threshold flag changes only on level crossing
// - Latched mode holds until software clears
// - Temporary latch clears on timer or software
// - Auto-clear mode clears by hardware or software
// - Global method: write 0x04/0x14 clears all
// - Global method ignores write data
// - Queue interrupts always behave latched
// - Per-bit method: 0x04 writes clear nothing
// - Per-bit: written ones clear, zeros keep
// - Per-bit: bit 5 clears all queue status bits
// - Default pins open-drain, active low
`default_nettype none

package msi_pkg;

	// Register offsets
	localparam logic [7:0] OFS_LEGACY_CLR = 8'h04;
	localparam logic [7:0] OFS_IRQ_EN     = 8'h06;
	localparam logic [7:0] OFS_FEATURE    = 8'h09;
	localparam logic [7:0] OFS_Q_STATUS   = 8'h0a;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFS_Q_CONTROL  = 8'h2d;
	localparam logic [7:0] OFS_Q_THRESH   = 8'h2e;
	localparam logic [7:0] OFS_Q_IRQ_STAT = 8'h2f;
	localparam logic [7:0] OFS_CLR_METHOD = 8'h31;
	localparam logic [7:0] OFS_PIN_CTRL   = 8'h33;
	localparam logic [7:0] OFS_TL_TIMER   = 8'h4a;

	// Field positions
	localparam int FEAT_INCLINE   = 0;
	localparam int FEAT_ANYMOTION = 2;
	localparam int FEAT_JOLT      = 3;
	localparam int FEAT_STEEP     = 4;
	localparam int STAT_QUEUE     = 5;
	localparam int STAT_SAMPLE    = 7;
	localparam int EN_SAMPLE      = 7;
	localparam int QCTL_ENABLE    = 5;
	localparam int CLR_PER_BIT    = 6;
	localparam int PIN1_PP        = 0;
	localparam int PIN1_AH        = 1;
	localparam int PIN2_PP        = 2;
	localparam int PIN2_AH        = 3;
	localparam int TL_MODE_LSB    = 6;

	// Reset values
	localparam logic [7:0] RST_ZERO   = 8'h00;
	localparam logic [7:0] RST_Q_THR  = 8'h10;
	localparam logic [2:0] RST_QFLAGS = 3'h1;

	// Sizes and timing
	localparam int unsigned Q_DEPTH_DEF = 32;
	localparam int unsigned CLK_MHZ     = 10;
	localparam int unsigned TL_UNIT_US  = 10000;
	localparam int unsigned TL_UNIT_CYC = TL_UNIT_US * CLK_MHZ;

	// Clearing behaviour of motion and sample bits
	typedef enum logic [1:0] {
		MSI_LATCHED = 2'b00,
		MSI_TEMP    = 2'b01,
		MSI_AUTO    = 2'b10
	} msi_mode_t;

	// One register port access
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} msi_bus_t;

	// Two-signal pin drive
	typedef struct packed {
		logic out;
		logic oe_n;
	} msi_pin_t;

endpackage // msi_pkg

`default_nettype wire

// ### hdl/msi_tl_timer.sv
`default_nettype none

module msi_tl_timer
	import msi_pkg::*;
#(
	parameter int unsigned UNIT_CYC = TL_UNIT_CYC
)(
	// Clocking
	input  wire logic       ref_clk,
	input  wire logic       rstn,
	input  wire logic       ce,
	// Control
	input  wire logic       run,
	input  wire logic       restart,
	input  wire logic [3:0] sel,
	// Result
	output logic            expire
);

	localparam int SW = (UNIT_CYC > 1) ? $clog2(UNIT_CYC) : 1;

	// Unit of at least one cycle, refused while elaborating
	if (UNIT_CYC < 1) begin : g_bad_unit
		$error("msi_tl_timer: UNIT_CYC must be at least 1");
	end

	logic [SW-1:0] sub_reg;  // Cycles within one unit
	logic [3:0]    step_reg; // Units elapsed

	// Period is (sel + 1) units; a fresh event restarts the wait
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			sub_reg  <= '0;
			step_reg <= 4'h0;
			expire   <= 1'b0;
		end else if (ce) begin
			expire <= 1'b0;
			if (!run || restart) begin
				sub_reg  <= '0;
				step_reg <= 4'h0;
			end else if (sub_reg == SW'(UNIT_CYC - 1)) begin
				sub_reg <= '0;
				if (step_reg == sel) begin
					expire   <= 1'b1;
					step_reg <= 4'h0;
				end else begin
					step_reg <= step_reg + 4'h1;
				end
			end else begin
				sub_reg <= sub_reg + SW'(1);
			end
		end
	end

endmodule // msi_tl_timer

`default_nettype wire

// ### hdl/msi_irq_unit.sv
`default_nettype none

module msi_irq_unit
	import msi_pkg::*;
#(
	parameter int unsigned TL_CYC  = TL_UNIT_CYC,
	parameter int unsigned Q_DEPTH = Q_DEPTH_DEF
)(
	// Clocking and reset
	input  wire logic                         ref_clk,
	input  wire logic                         rstn,
	input  wire logic                         ce,
	input  wire logic                         software_reset,
	// Register port
	input  wire msi_bus_t                     bus,
	output logic [7:0]                        rdata,
	// Sample and motion events
	input  wire logic                         sample_done,
	input  wire logic                         z_accum_start,
	input  wire logic [4:0]                   motion_evt,
	input  wire logic [4:0]                   motion_cond,
	// Queue activity
	input  wire logic                         q_wr,
	input  wire logic                         q_rd,
	input  wire logic [$clog2(Q_DEPTH+1)-1:0] q_count,
	// Interrupt pins
	output var msi_pin_t                      first_irq_pin,
	output var msi_pin_t                      second_irq_pin
);

	localparam int QW = $clog2(Q_DEPTH + 1);

	// Threshold register is 8 bits wide, so deeper queues are refused
	if (Q_DEPTH < 2 || Q_DEPTH > 255) begin : g_bad_depth
		$error("msi_irq_unit: Q_DEPTH out of range");
	end
	if (TL_CYC < 1) begin : g_bad_unit
		$error("msi_irq_unit: TL_CYC must be at least 1");
	end

	////////////////////////////////////////////////////////////////
	// Decoding helpers

	// Write strobe for one offset
	function automatic logic wr_hit(msi_bus_t b, logic [7:0] ofs);
		return b.wr && (b.addr == ofs);
	endfunction

	// Feature gating per motion source
	function automatic logic [4:0] feat_ok(logic [7:0] f);
		logic am;
		am = f[FEAT_ANYMOTION];
		return {f[FEAT_STEEP] & am, f[FEAT_JOLT] & am, am,
			f[FEAT_INCLINE], f[FEAT_INCLINE]};
	endfunction

	////////////////////////////////////////////////////////////////
	// Register state

	logic [7:0] ien_reg;    // Interrupt enables
	logic [7:0] feat_reg;   // Motion feature enables
	logic [7:0] qctl_reg;   // Queue control
	logic [7:0] qthr_reg;   // Queue threshold count
	logic [7:0] clrm_reg;   // Clearing method
	logic [7:0] pinc_reg;   // Pin drive and polarity
	logic [7:0] tlt_reg;    // Mode and timer period
	logic [4:0] mot_reg;    // Latched motion status
	logic       srdy_reg;   // Sample-ready flag
	logic [2:0] qst_reg;    // Latched queue status
	logic [2:0] qflag_reg;  // Live queue flags
	logic [2:0] qprev_reg;  // Qualified flags last cycle
	logic [4:0] cond_reg;   // Motion conditions last cycle
	msi_pin_t   pin_reg [2]; // Pin drive flops

	msi_mode_t  mode;
	logic       tl_expire;

	// Undefined mode code falls back to latched
	always_comb begin
		unique case (tlt_reg[TL_MODE_LSB +: 2])
			2'b00:   mode = MSI_LATCHED;
			2'b01:   mode = MSI_TEMP;
			2'b10:   mode = MSI_AUTO;
			default: mode = MSI_LATCHED;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// Clear decode

	logic       wr14;
	logic       wr04;
	logic       rd14;
	logic       gclr;
	logic       pclr;
	logic [4:0] mot_swclr;
	logic       srdy_swclr;
	logic       q_swclr;

	assign wr14 = wr_hit(bus, OFS_IRQ_STATUS);
	assign wr04 = wr_hit(bus, OFS_LEGACY_CLR);
	assign rd14 = bus.rd && (bus.addr == OFS_IRQ_STATUS);

	// Global method: address alone makes the pulse
	assign gclr = !clrm_reg[CLR_PER_BIT] && (wr14 || wr04);
	// Per-bit method ignores the legacy clear offset
	assign pclr = clrm_reg[CLR_PER_BIT] && wr14;

	// Software clear masks
	assign mot_swclr  = gclr ? 5'h1f : (pclr ? bus.wdata[4:0] : 5'h00);
	assign srdy_swclr = gclr || (pclr && bus.wdata[STAT_SAMPLE]) || rd14;
	assign q_swclr    = gclr || (pclr && bus.wdata[STAT_QUEUE]);

	////////////////////////////////////////////////////////////////
	// Set and hardware clear terms

	logic [4:0] mot_set;
	logic [4:0] mot_hwclr;
	logic       srdy_hwclr;
	logic [2:0] q_qual;
	logic [2:0] q_set;

	// Event masked by feature and enable before status
	assign mot_set = motion_evt & feat_ok(feat_reg) & ien_reg[4:0];

	// Timer, condition end or accumulation start clears, never queue bits
	always_comb begin
		mot_hwclr  = 5'h00;
		srdy_hwclr = 1'b0;
		unique case (mode)
			MSI_TEMP: begin
				mot_hwclr  = {5{tl_expire}};
				srdy_hwclr = tl_expire;
			end
			MSI_AUTO: begin
				mot_hwclr  = cond_reg & ~motion_cond;
				srdy_hwclr = z_accum_start;
			end
			MSI_LATCHED: begin
				mot_hwclr  = 5'h00;
				srdy_hwclr = 1'b0;
			end
		endcase
	end

	// Queue flags count only while the queue is enabled
	assign q_qual = qflag_reg & {3{qctl_reg[QCTL_ENABLE]}};
	assign q_set  = q_qual & ~qprev_reg & qctl_reg[2:0];

	////////////////////////////////////////////////////////////////
	// Configuration registers

	// Software reset returns every setting to its default
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			ien_reg  <= RST_ZERO;
			feat_reg <= RST_ZERO;
			qctl_reg <= RST_ZERO;
			qthr_reg <= RST_Q_THR;
			clrm_reg <= RST_ZERO;
			pinc_reg <= RST_ZERO;
			tlt_reg  <= RST_ZERO;
		end else if (ce) begin
			if (software_reset) begin
				ien_reg  <= RST_ZERO;
				feat_reg <= RST_ZERO;
				qctl_reg <= RST_ZERO;
				qthr_reg <= RST_Q_THR;
				clrm_reg <= RST_ZERO;
				pinc_reg <= RST_ZERO;
				tlt_reg  <= RST_ZERO;
			end else if (bus.wr) begin
				unique case (bus.addr)
					OFS_IRQ_EN:     ien_reg  <= bus.wdata;
					OFS_FEATURE:    feat_reg <= bus.wdata;
					OFS_Q_CONTROL:  qctl_reg <= bus.wdata;
					OFS_Q_THRESH:   qthr_reg <= bus.wdata;
					OFS_CLR_METHOD: clrm_reg <= bus.wdata;
					OFS_PIN_CTRL:   pinc_reg <= bus.wdata;
					OFS_TL_TIMER:   tlt_reg  <= bus.wdata;
					default:        ;  // Status and unknown offsets keep no data
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Motion and sample status

	// A set in the clearing cycle wins, so no event is lost
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			mot_reg  <= 5'h00;
			srdy_reg <= 1'b0;
			cond_reg <= 5'h00;
		end else if (ce) begin
			if (software_reset) begin
				mot_reg  <= 5'h00;
				srdy_reg <= 1'b0;
				cond_reg <= 5'h00;
			end else begin
				mot_reg  <= mot_set | (mot_reg & ~(mot_swclr | mot_hwclr));
				// Set once per sample, no enable involved
				srdy_reg <= sample_done | (srdy_reg & ~(srdy_swclr | srdy_hwclr));
				cond_reg <= motion_cond;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Queue flags and queue status

	// Flags move only on a queue access; threshold compare at the
	// access means it flips only when the count crosses the level
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			qflag_reg <= RST_QFLAGS;
		end else if (ce) begin
			if (software_reset) begin
				qflag_reg <= RST_QFLAGS;
			end else if (q_wr || q_rd) begin
				qflag_reg[0] <= (q_count == QW'(0));
				qflag_reg[1] <= (q_count == QW'(Q_DEPTH));
				qflag_reg[2] <= ({{(8 - QW){1'b0}}, q_count} >= qthr_reg);
			end
		end
	end

	// Queue bits ignore timer and auto-clear: latched only
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			qst_reg   <= 3'h0;
			qprev_reg <= 3'h0;
		end else if (ce) begin
			if (software_reset) begin
				qst_reg   <= 3'h0;
				qprev_reg <= 3'h0;
			end else begin
				qst_reg   <= q_set | (qst_reg & ~{3{q_swclr}});
				qprev_reg <= q_qual;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Temporary latch timer

	msi_tl_timer #(
		.UNIT_CYC (TL_CYC)
	) u_timer (
		.ref_clk (ref_clk),
		.rstn    (rstn),
		.ce      (ce),
		.run     ((mode == MSI_TEMP) && ((|mot_reg) || srdy_reg)),
		.restart ((|mot_set) || sample_done),
		.sel     (tlt_reg[3:0]),
		.expire  (tl_expire)
	);

	////////////////////////////////////////////////////////////////
	// Read data

	// Registered answer one cycle after the read strobe
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
		end else if (ce && bus.rd) begin
			unique case (bus.addr)
				OFS_IRQ_EN:     rdata <= ien_reg;
				OFS_FEATURE:    rdata <= feat_reg;
				OFS_Q_STATUS:   rdata <= {5'h00, qflag_reg};
				OFS_IRQ_STATUS: rdata <= {srdy_reg, 1'b0, |qst_reg, mot_reg};
				OFS_Q_CONTROL:  rdata <= qctl_reg;
				OFS_Q_THRESH:   rdata <= qthr_reg;
				OFS_Q_IRQ_STAT: rdata <= {5'h00, qst_reg};
				OFS_CLR_METHOD: rdata <= clrm_reg;
				OFS_PIN_CTRL:   rdata <= pinc_reg;
				OFS_TL_TIMER:   rdata <= tlt_reg;
				default:        rdata <= 8'h00; // Unmapped reads as zero
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Interrupt pins

	logic [1:0] req;
	logic [1:0] pp_sel;
	logic [1:0] ah_sel;

	// Sample/motion on the first pin, queue on the second
	assign req[0] = (|mot_reg) || (srdy_reg && ien_reg[EN_SAMPLE]);
	assign req[1] = |qst_reg;
	assign pp_sel = {pinc_reg[PIN2_PP], pinc_reg[PIN1_PP]};
	assign ah_sel = {pinc_reg[PIN2_AH], pinc_reg[PIN1_AH]};

	// Open drain only pulls low, so it releases at the high level
	for (genvar p = 0; p < 2; p++) begin : g_pin
		always_ff @(posedge ref_clk or negedge rstn) begin
			if (!rstn) begin
				pin_reg[p] <= '{out: 1'b0, oe_n: 1'b1};
			end else if (ce) begin
				pin_reg[p].out  <= ah_sel[p] ? req[p] : ~req[p];
				pin_reg[p].oe_n <= pp_sel[p] ? 1'b0 : (ah_sel[p] ? req[p] : ~req[p]);
			end
		end
	end

	assign first_irq_pin  = pin_reg[0];
	assign second_irq_pin = pin_reg[1];

	////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);

	chk_mot_gate: assert property (
		ce && !software_reset && motion_evt[2] && !ien_reg[2] && !mot_reg[2] |=> !mot_reg[2])
		else $error("motion status set without enable");

	chk_jolt_feat: assert property (
		ce && !feat_reg[FEAT_ANYMOTION] && !mot_reg[3] |=> !mot_reg[3])
		else $error("jolt set without any-motion feature");

	chk_srdy_live: assert property (
		ce && !software_reset && sample_done |=> srdy_reg)
		else $error("sample flag missed a sample");

	chk_srdy_rdclr: assert property (
		ce && !software_reset && rd14 && !sample_done |=> !srdy_reg && rdata[STAT_SAMPLE] == $past(srdy_reg))
		else $error("sample flag not cleared by read");

	chk_glob_clr: assert property (
		ce && !software_reset && gclr && motion_evt == 5'h00 && !sample_done |=> mot_reg == 5'h00 && !srdy_reg)
		else $error("global clear left bits pending");

	chk_perbit_keep: assert property (
		ce && pclr && !bus.wdata[0] && mot_reg[0] && !software_reset && mode == MSI_LATCHED |=> mot_reg[0])
		else $error("per-bit clear removed an unselected bit");

	chk_q_latched: assert property (
		ce && !software_reset && qst_reg[0] && !q_swclr |=> qst_reg[0])
		else $error("queue bit cleared without software");

	chk_tl_expire: assert property (
		ce && !software_reset && tl_expire && mode == MSI_TEMP && mot_set == 5'h00 |=> mot_reg == 5'h00)
		else $error("timer expiry did not clear motion bits");

	chk_pin_drive: assert property (
		ce && (|mot_reg) && pinc_reg[1:0] == 2'b00 |=> !first_irq_pin.out && !first_irq_pin.oe_n)
		else $error("first pin not pulled low while pending");

	chk_swr_default: assert property (
		ce && software_reset |=> qthr_reg == RST_Q_THR && qflag_reg == RST_QFLAGS)
		else $error("software reset defaults wrong");

	cov_glob_clear: cover property (ce && gclr && (|mot_reg));
	cov_perbit_q:   cover property (ce && pclr && bus.wdata[STAT_QUEUE] && (|qst_reg));
	cov_tl_timeout: cover property (ce && tl_expire && (|mot_reg));
	cov_q_full:     cover property (ce && q_set[1]);

endmodule // msi_irq_unit

`default_nettype wire

// ### test/msi_host_model.sv
`default_nettype none

module msi_host_model
	import msi_pkg::*;
(
	// Clock
	input  wire logic       ref_clk,
	// Register port toward the unit
	output var msi_bus_t    bus,
	input  wire logic [7:0] rdata,
	// Interrupt pins and their board levels
	input  wire msi_pin_t   first_irq_pin,
	input  wire msi_pin_t   second_irq_pin,
	output logic            first_irq_lvl,
	output logic            second_irq_lvl
);
	timeunit 1ns;
	timeprecision 1ns;

	////////////////////////////////////////////////////////////////////////
	// Board pull-ups: a released pin reads high
	assign first_irq_lvl  = first_irq_pin.oe_n ? 1'b1 : first_irq_pin.out;
	assign second_irq_lvl = second_irq_pin.oe_n ? 1'b1 : second_irq_pin.out;

	// Idle bus: strobes low, nothing at time zero left unknown
	initial begin
		bus = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// Idle bus shows flipped address and data, never stale values
	task automatic release_bus();
		bus.wr    = 1'b0;
		bus.rd    = 1'b0;
		bus.addr  = ~bus.addr;
		bus.wdata = ~bus.wdata;
	endtask

	// One write: leading edge wait keeps back-to-back calls apart
	task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
		@(negedge ref_clk);
		bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge ref_clk);
		release_bus();
	endtask

	// One read: data is registered, so it is taken a cycle later
	task automatic bus_read(input logic [7:0] a, output logic [7:0] d);
		@(negedge ref_clk);
		bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge ref_clk);
		d = rdata;
		release_bus();
	endtask

	// Interrupt service: read status first, then write all ones to clear
	task automatic service(output logic [7:0] st);
		bus_read(OFS_IRQ_STATUS, st);
		bus_write(OFS_IRQ_STATUS, 8'hff);
	endtask

endmodule // msi_host_model

`default_nettype wire

// ### test/msi_irq_unit_tb_top.sv
`default_nettype none

module msi_irq_unit_tb_top
	import msi_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	// Short timer unit keeps the temp-latch run brief
	localparam int unsigned TL_SIM = 4;

	// One table row: setup, event and expected status
	typedef struct packed {
		logic [7:0] feat;
		logic [7:0] en;
		logic [4:0] evt;
		logic [7:0] stat;
	} msi_row_t;

	logic                ref_clk;          // 10 MHz clock
	logic                rstn;             // Async reset, active low
	logic                software_reset;   // Sync reset pulse
	logic                sample_done;      // Sample produced
	logic                z_accum;          // Z accumulation start pulse
	logic [4:0]          motion_evt;       // Motion event pulses
	logic [4:0]          motion_cond;      // Motion condition levels
	logic                q_wr;             // Queue write strobe
	logic                q_rd;             // Queue read strobe
	logic [5:0]          q_count;          // Queue fill after access
	msi_bus_t            bus;              // Register access from host
	logic [7:0]          rdata;            // Register read data
	msi_pin_t            pin1;             // First request pin
	msi_pin_t            pin2;             // Second request pin
	logic                lvl1;             // Board level of first pin
	logic                lvl2;             // Board level of second pin
	logic [7:0]          d;                // Scratch read value
	int                  miscompares = 0;  // Mismatch count
	int                  compares    = 0;  // Comparison count
	msi_row_t            rows [8] = '{
		'{8'h01, 8'h01, 5'h01, 8'h01}, '{8'h01, 8'h02, 5'h02, 8'h02},
		'{8'h04, 8'h04, 5'h04, 8'h04}, '{8'h0c, 8'h08, 5'h08, 8'h08},
		'{8'h08, 8'h08, 5'h08, 8'h00}, '{8'h14, 8'h10, 5'h10, 8'h10},
		'{8'h00, 8'h01, 5'h01, 8'h00}, '{8'h05, 8'h00, 5'h05, 8'h00}};

	////////////////////////////////////////////////////////////////////////
	// Unit, clock enable always on
	msi_irq_unit #(.TL_CYC(TL_SIM), .Q_DEPTH(32)) dut (
		.ref_clk(ref_clk), .rstn(rstn), .ce(1'b1), .software_reset(software_reset),
		.bus(bus), .rdata(rdata), .sample_done(sample_done), .z_accum_start(z_accum),
		.motion_evt(motion_evt), .motion_cond(motion_cond), .q_wr(q_wr), .q_rd(q_rd),
		.q_count(q_count), .first_irq_pin(pin1), .second_irq_pin(pin2));

	// Processor on the far side
	msi_host_model host (
		.ref_clk(ref_clk), .bus(bus), .rdata(rdata), .first_irq_pin(pin1),
		.second_irq_pin(pin2), .first_irq_lvl(lvl1), .second_irq_lvl(lvl2));

	// Clock generator
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] v;
		host.bus_read(a, v);
		chk(what, exp, v);
	endtask

	// Event pulses start on a falling edge; pin settles two edges on
	task automatic pulse(input logic [4:0] e, input logic s);
		motion_evt  = e;
		sample_done = s;
		tick(1);
		motion_evt  = 5'h00;
		sample_done = 1'b0;
		tick(1);
	endtask

	// Queue access with the fill level it leaves behind
	task automatic qacc(input logic wr, input logic [5:0] cnt);
		q_count = cnt;
		q_wr    = wr;
		q_rd    = ~wr;
		tick(1);
		q_wr = 1'b0;
		q_rd = 1'b0;
	endtask

	// Bounded wait for the first pin to go inactive
	task automatic wait_lvl1(input int lim);
		int k;
		for (k = 0; k < lim && lvl1 !== 1'b1; k++) begin
			tick(1);
		end
		chk("first pin release", 8'h01, {7'h00, lvl1});
	endtask

	task automatic print_verdict();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rstn = 1'b0;
		software_reset = 1'b0;
		sample_done = 1'b0;
		motion_evt = 5'h00;
		motion_cond = 5'h00;
		q_wr = 1'b0;
		q_rd = 1'b0;
		q_count = 6'h00;
		z_accum = 1'b0;
		tick(2);
		rstn = 1'b1;
		tick(1);
		// Motion table: gate by feature and enable, then latch
		foreach (rows[i]) begin
			host.bus_write(OFS_FEATURE, rows[i].feat);
			host.bus_write(OFS_IRQ_EN, rows[i].en);
			pulse(rows[i].evt, 1'b0);
			chk("pin1 on event", {7'h00, rows[i].stat == 8'h00}, {7'h00, lvl1});
			host.service(d);
			chk("motion status", rows[i].stat, d);
			tick(1);
			chk("pin1 after clear", 8'h01, {7'h00, lvl1});
		end
		$display("test motion table done");
		// Reset values and default pins
		rdchk("queue flags", OFS_Q_STATUS, 8'h01);
		rdchk("threshold", OFS_Q_THRESH, 8'h10);
		chk("pin2 idle", 8'h01, {7'h00, lvl2});
		chk("pin1 drive", 8'h03, {6'h00, pin1});
		$display("test reset values done");
		// Sample flag: live without enable, cleared by read
		host.bus_write(OFS_IRQ_EN, 8'h00);
		pulse(5'h00, 1'b1);
		chk("pin1 masked sample", 8'h01, {7'h00, lvl1});
		rdchk("sample live", OFS_IRQ_STATUS, 8'h80);
		rdchk("sample read clear", OFS_IRQ_STATUS, 8'h00);
		host.bus_write(OFS_IRQ_EN, 8'h80);
		pulse(5'h00, 1'b1);
		chk("pin1 sample", 8'h00, {7'h00, lvl1});
		// Global clear through the legacy address, data ignored
		host.bus_write(OFS_FEATURE, 8'h05);
		host.bus_write(OFS_IRQ_EN, 8'h05);
		pulse(5'h05, 1'b0);
		host.bus_write(OFS_LEGACY_CLR, 8'h00);
		rdchk("global clear", OFS_IRQ_STATUS, 8'h00);
		$display("test sample and global done");
		// Per-bit method
		host.bus_write(OFS_CLR_METHOD, 8'h40);
		pulse(5'h05, 1'b0);
		host.bus_write(OFS_IRQ_STATUS, 8'h04);
		rdchk("per-bit clear", OFS_IRQ_STATUS, 8'h01);
		host.bus_write(OFS_LEGACY_CLR, 8'hff);
		rdchk("legacy ignored", OFS_IRQ_STATUS, 8'h01);
		host.bus_write(OFS_IRQ_STATUS, 8'h01);
		// Queue threshold crossing under per-bit method
		host.bus_write(OFS_Q_CONTROL, 8'h04);
		qacc(1'b1, 6'h10);
		tick(2);
		rdchk("queue off status", OFS_Q_IRQ_STAT, 8'h00);
		qacc(1'b0, 6'h0f);
		host.bus_write(OFS_Q_CONTROL, 8'h24);
		qacc(1'b1, 6'h10);
		tick(2);
		chk("pin2 threshold", 8'h00, {7'h00, lvl2});
		rdchk("queue flags thr", OFS_Q_STATUS, 8'h04);
		rdchk("queue status", OFS_Q_IRQ_STAT, 8'h04);
		rdchk("queue summary", OFS_IRQ_STATUS, 8'h20);
		host.bus_write(OFS_IRQ_STATUS, 8'h20);
		rdchk("queue bit5 clear", OFS_Q_IRQ_STAT, 8'h00);
		qacc(1'b0, 6'h0f);
		tick(1);
		rdchk("queue below thr", OFS_Q_STATUS, 8'h00);
		$display("test per-bit and queue done");
		// Temp latch: timer clears motion, queue stays latched
		host.bus_write(OFS_CLR_METHOD, 8'h00);
		host.bus_write(OFS_TL_TIMER, 8'h40);
		qacc(1'b1, 6'h10);
		pulse(5'h04, 1'b0);
		chk("pin1 temp set", 8'h00, {7'h00, lvl1});
		wait_lvl1(40);
		rdchk("queue survives timer", OFS_Q_IRQ_STAT, 8'h04);
		host.bus_write(OFS_LEGACY_CLR, 8'h5a);
		rdchk("global queue clear", OFS_Q_IRQ_STAT, 8'h00);
		// Auto clear on condition end
		host.bus_write(OFS_TL_TIMER, 8'h80);
		motion_cond = 5'h04;
		pulse(5'h04, 1'b0);
		chk("pin1 auto set", 8'h00, {7'h00, lvl1});
		motion_cond = 5'h00;
		wait_lvl1(8);
		// Auto clear of the sample flag at the start of accumulation
		host.bus_write(OFS_IRQ_EN, 8'h85);
		pulse(5'h00, 1'b1);
		chk("pin1 auto sample", 8'h00, {7'h00, lvl1});
		z_accum = 1'b1;
		tick(1);
		z_accum = 1'b0;
		tick(1);
		chk("pin1 z clear", 8'h01, {7'h00, lvl1});
		// Pin 1 push-pull active high
		host.bus_write(OFS_PIN_CTRL, 8'h03);
		tick(1);
		chk("pin1 pp idle", 8'h00, {6'h00, pin1});
		pulse(5'h04, 1'b0);
		chk("pin1 pp active", 8'h02, {6'h00, pin1});
		$display("test clearing modes and pins done");
		// Software reset restores defaults
		software_reset = 1'b1;
		tick(1);
		software_reset = 1'b0;
		rdchk("swr threshold", OFS_Q_THRESH, 8'h10);
		rdchk("swr pin ctrl", OFS_PIN_CTRL, 8'h00);
		rdchk("swr queue flags", OFS_Q_STATUS, 8'h01);
		$display("test software reset done");
		print_verdict();
	end

endmodule // msi_irq_unit_tb_top

`default_nettype wire
